// File: design/dscr_brk_bank.sv
/*
  Four instruction breakpoint comparators, equality or inequality per
  control word, gated by per-thread enables.
  Assumes pc and thread describe the instruction issuing this cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module dscr_brk_bank
  import dscr_pkg::*;
(
  dscr_brk_if.bank b
);
  // ---------------------------------------------------------------
  // Comparators
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < DSCR_NUM_BRK; g++) begin : gen_cmp
      logic eq;
      logic thr_ok;
      assign eq     = (b.pc == b.addr[g]);
      assign thr_ok = b.ctrl[g][DSCR_BCTRL_THR_LO + b.thread[2:0]];
      assign b.hit[g] = b.valid & b.ctrl[g][DSCR_BCTRL_EN] & thr_ok
                        & (b.ctrl[g][DSCR_BCTRL_NE] ? !eq : eq);
    end
  endgenerate
endmodule
`default_nettype wire

// File: design/dscr_scratch_mem.sv
/*
  Eight-word debugger scratch store with two write ports: the status
  space and the tile configuration space. Read data is registered.
  Assumes the two ports rarely write together; port A wins a tie.
*/
`timescale 1ns/1ns
`default_nettype none
module dscr_scratch_mem
  import dscr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        a_we_i,
  input  wire logic [2:0]  a_addr_i,
  input  wire logic [31:0] a_wdata_i,
  output logic      [31:0] a_rdata_o,
  input  wire logic        b_we_i,
  input  wire logic [2:0]  b_addr_i,
  input  wire logic [31:0] b_wdata_i,
  output logic      [31:0] b_rdata_o
);
  logic [31:0] mem      [DSCR_NUM_SCRATCH];
  logic [31:0] next_mem [DSCR_NUM_SCRATCH];

  always_comb begin
    for (int i = 0; i < DSCR_NUM_SCRATCH; i++) begin
      next_mem[i] = mem[i];
    end
    if (b_we_i) begin
      next_mem[b_addr_i] = b_wdata_i;
    end
    if (a_we_i) begin
      next_mem[a_addr_i] = a_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < DSCR_NUM_SCRATCH; i++) begin
        mem[i] <= DSCR_RESET_WORD;
      end
      a_rdata_o <= DSCR_RESET_WORD;
      b_rdata_o <= DSCR_RESET_WORD;
    end else begin
      for (int i = 0; i < DSCR_NUM_SCRATCH; i++) begin
        mem[i] <= next_mem[i];
      end
      a_rdata_o <= mem[a_addr_i];
      b_rdata_o <= mem[b_addr_i];
    end
  end
endmodule
`default_nettype wire

// File: design/dscr_top.sv
/*
  Debug state capture registers for one tile: entry snapshot, cause and
  data capture, remote fetch operands, stop mask, scratch, breakpoints.
  Assumes the core supplies saved thread state, the debug entry strobe
  and the issuing pc; register access is an indexed status-space port.
*/
// Operation
// - On debug entry copy saved status word into register 0x10.
// - Status bits 7,6,4,3,2,1,0 hold issue, pause, mode, enable flags.
// - Bit 10 address space, bit 9 writable, bit 8 read-only live issue mode (issue_mode_i, one cycle late).
// - On debug entry capture saved program counter into 0x11.
// - On debug entry capture saved stack pointer into 0x12.
// - Remote fetch thread number in 0x13 bits 7:0, rest reserved.
// - Remote fetch register index in 0x14 bits 4:0.
// - Cause code bits 2:0, reset zero, codes one to five.
// - Bits 17:16 give firing breakpoint index, zero for host, call.
// - Simultaneous hits report the lowest-numbered breakpoint.
// - Bits 15:8 give causing thread, zero for host requests.
// - Data register 0x16 gets watch address or resource identifier.
// - Threads set in stop mask 0x18 stay held after debug return.
// - Eight scratch words 0x20-0x27 shared with tile config space.
// - Four breakpoint addresses 0x30-0x33 raise debug on pc match.
// - Per-breakpoint control: enable, inequality select, thread mask.
`timescale 1ns/1ns
`default_nettype none
module dscr_top
  import dscr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // Status-space register port
  input  wire logic        ps_wr_i,
  input  wire logic        ps_rd_i,
  input  wire logic [7:0]  ps_addr_i,
  input  wire logic [31:0] ps_wdata_i,
  output logic      [31:0] ps_rdata_o,
  // Tile configuration view of scratch
  input  wire logic        cfg_wr_i,
  input  wire logic [2:0]  cfg_addr_i,
  input  wire logic [31:0] cfg_wdata_i,
  output logic      [31:0] cfg_rdata_o,
  // Core state at debug entry
  input  wire logic        debug_enter_i,
  input  wire logic        debug_exit_i,
  input  wire logic [2:0]  entry_cause_i,
  input  wire logic [7:0]  entry_thread_i,
  input  wire logic [1:0]  watch_index_i,
  input  wire logic [31:0] watch_data_i,
  input  wire logic [31:0] saved_status_word_i,
  input  wire logic        issue_mode_i,
  input  wire logic [31:0] saved_program_counter_i,
  input  wire logic [31:0] saved_stack_pointer_i,
  // Issuing instruction
  input  wire logic        issue_valid_i,
  input  wire logic [31:0] issue_pc_i,
  input  wire logic [7:0]  issue_thread_i,
  // Results
  output logic             debug_mode_o,
  output logic             brk_req_o,
  output logic [7:0]       brk_thread_o,
  output logic [1:0]       brk_index_o,
  output logic [7:0]       thread_hold_o,
  output logic [7:0]       fetch_thread_o,
  output logic [4:0]       fetch_reg_o
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [31:0] status,    next_status;
  logic [31:0] saved_program_counter,       next_spc;
  logic [31:0] saved_stack_pointer,       next_ssp;
  logic [31:0] fthr,      next_fthr;
  logic [31:0] freg,      next_freg;
  logic [31:0] cause,     next_cause;
  logic [31:0] edata,     next_edata;
  logic [31:0] stopm,     next_stopm;
  logic [31:0] baddr     [DSCR_NUM_BRK];
  logic [31:0] next_baddr[DSCR_NUM_BRK];
  logic [31:0] bctrl     [DSCR_NUM_BRK];
  logic [31:0] next_bctrl[DSCR_NUM_BRK];
  logic        dmode,     next_dmode;
  logic        issue_q,   next_issue_q;
  logic        sel_scr_q, next_sel_scr_q;
  logic [31:0] rdata_q,   next_rdata_q;
  logic        breq,      next_breq;
  logic [7:0]  bthr,      next_bthr;
  logic [1:0]  bidx,      next_bidx;
  logic [7:0]  hold,      next_hold;

  logic        dwr;
  logic        scr_hit;
  logic [31:0] scr_rdata;
  logic [1:0]  low_idx;
  logic        any_hit;

  dscr_brk_if bif ();

  assign bif.pc     = issue_pc_i;
  assign bif.thread = issue_thread_i;
  assign bif.valid  = issue_valid_i & !dmode;
  assign bif.addr   = baddr;
  assign bif.ctrl   = bctrl;

  dscr_brk_bank u_bank (
    .b (bif.bank)
  );

  assign dwr     = ps_wr_i & dmode;
  assign scr_hit = (ps_addr_i >= DSCR_SCRATCH_BASE) && (ps_addr_i <= DSCR_SCRATCH_LAST);

  dscr_scratch_mem u_scratch (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .a_we_i    (dwr & scr_hit),
    .a_addr_i  (ps_addr_i[2:0]),
    .a_wdata_i (ps_wdata_i),
    .a_rdata_o (scr_rdata),
    .b_we_i    (cfg_wr_i),
    .b_addr_i  (cfg_addr_i),
    .b_wdata_i (cfg_wdata_i),
    .b_rdata_o (cfg_rdata_o)
  );

  // ---------------------------------------------------------------
  // Breakpoint priority
  // ---------------------------------------------------------------
  // lowest index wins
  always_comb begin
    low_idx = 2'h0;
    for (int i = DSCR_NUM_BRK - 1; i >= 0; i--) begin
      if (bif.hit[i]) begin
        low_idx = i[1:0];
      end
    end
    any_hit = |bif.hit;
  end

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    next_status    = status;
    next_spc       = saved_program_counter;
    next_ssp       = saved_stack_pointer;
    next_fthr      = fthr;
    next_freg      = freg;
    next_cause     = cause;
    next_edata     = edata;
    next_stopm     = stopm;
    next_baddr     = baddr;
    next_bctrl     = bctrl;
    next_dmode     = dmode;
    next_issue_q   = issue_mode_i;
    next_sel_scr_q = ps_rd_i & scr_hit;
    next_rdata_q   = DSCR_RESET_WORD;
    next_breq      = any_hit;
    next_bthr      = issue_thread_i;
    next_bidx      = low_idx;
    next_hold      = hold;

    if (dwr) begin
      case (ps_addr_i)
        DSCR_SAVED_STATUS: next_status = ps_wdata_i & DSCR_STATUS_WMASK;
        DSCR_SAVED_PC:     next_spc    = ps_wdata_i;
        DSCR_SAVED_SP:     next_ssp    = ps_wdata_i;
        DSCR_FETCH_THREAD: next_fthr   = ps_wdata_i & DSCR_THREAD_MASK;
        DSCR_FETCH_REG:    next_freg   = ps_wdata_i & DSCR_REGIDX_MASK;
        DSCR_CAUSE:        next_cause  = ps_wdata_i & DSCR_CAUSE_MASK;
        DSCR_EVENT_DATA:   next_edata  = ps_wdata_i;
        DSCR_STOP_MASK:    next_stopm  = ps_wdata_i & DSCR_THREAD_MASK;
        default: begin
          if (ps_addr_i >= DSCR_BRK_ADDR_BASE && ps_addr_i <= DSCR_BRK_ADDR_LAST) begin
            next_baddr[ps_addr_i[1:0]] = ps_wdata_i;
          end
          if (ps_addr_i >= DSCR_BRK_CTRL_BASE && ps_addr_i <= DSCR_BRK_CTRL_LAST) begin
            next_bctrl[ps_addr_i[1:0]] = ps_wdata_i & DSCR_BCTRL_MASK;
          end
        end
      endcase
    end

    // Entry capture overrides a same-cycle write
    if (debug_enter_i && !dmode) begin
      next_dmode  = 1'b1;
      next_status = saved_status_word_i & DSCR_STATUS_WMASK;
      next_spc    = saved_program_counter_i;
      next_ssp    = saved_stack_pointer_i;
      next_cause  = {24'h00_0000, 5'h00, entry_cause_i};
      if (entry_cause_i != DSCR_CAUSE_HOST) begin
        next_cause[15:8] = entry_thread_i;
      end
      if (entry_cause_i >= DSCR_CAUSE_IBRK) begin
        next_cause[17:16] = watch_index_i;
      end
      if (entry_cause_i == DSCR_CAUSE_DWAT || entry_cause_i == DSCR_CAUSE_RWAT) begin
        next_edata = watch_data_i;
      end
      next_hold = 8'hFF;
    end else if (debug_exit_i && dmode) begin
      next_dmode = 1'b0;
      next_hold  = stopm[7:0];
    end

    if (ps_rd_i) begin
      case (ps_addr_i)
        DSCR_SAVED_STATUS: next_rdata_q = status | ({31'h0000_0000, issue_q} << DSCR_STATUS_ISSUE);
        DSCR_SAVED_PC:     next_rdata_q = saved_program_counter;
        DSCR_SAVED_SP:     next_rdata_q = saved_stack_pointer;
        DSCR_FETCH_THREAD: next_rdata_q = fthr;
        DSCR_FETCH_REG:    next_rdata_q = freg;
        DSCR_CAUSE:        next_rdata_q = cause;
        DSCR_EVENT_DATA:   next_rdata_q = edata;
        DSCR_STOP_MASK:    next_rdata_q = stopm;
        default: begin
          if (ps_addr_i >= DSCR_BRK_ADDR_BASE && ps_addr_i <= DSCR_BRK_ADDR_LAST) begin
            next_rdata_q = baddr[ps_addr_i[1:0]];
          end
          if (ps_addr_i >= DSCR_BRK_CTRL_BASE && ps_addr_i <= DSCR_BRK_CTRL_LAST) begin
            next_rdata_q = bctrl[ps_addr_i[1:0]];
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      status    <= DSCR_RESET_WORD;
      saved_program_counter       <= DSCR_RESET_WORD;
      saved_stack_pointer       <= DSCR_RESET_WORD;
      fthr      <= DSCR_RESET_WORD;
      freg      <= DSCR_RESET_WORD;
      cause     <= DSCR_RESET_WORD;
      edata     <= DSCR_RESET_WORD;
      stopm     <= DSCR_RESET_WORD;
      for (int i = 0; i < DSCR_NUM_BRK; i++) begin
        baddr[i] <= DSCR_RESET_WORD;
        bctrl[i] <= DSCR_RESET_WORD;
      end
      dmode     <= 1'b0;
      issue_q   <= 1'b0;
      sel_scr_q <= 1'b0;
      rdata_q   <= DSCR_RESET_WORD;
      breq      <= 1'b0;
      bthr      <= 8'h00;
      bidx      <= 2'h0;
      hold      <= 8'h00;
    end else begin
      status    <= next_status;
      saved_program_counter       <= next_spc;
      saved_stack_pointer       <= next_ssp;
      fthr      <= next_fthr;
      freg      <= next_freg;
      cause     <= next_cause;
      edata     <= next_edata;
      stopm     <= next_stopm;
      baddr     <= next_baddr;
      bctrl     <= next_bctrl;
      dmode     <= next_dmode;
      issue_q   <= next_issue_q;
      sel_scr_q <= next_sel_scr_q;
      rdata_q   <= next_rdata_q;
      breq      <= next_breq;
      bthr      <= next_bthr;
      bidx      <= next_bidx;
      hold      <= next_hold;
    end
  end

  // Scratch read data is registered inside the memory; mux is one flop late
  assign ps_rdata_o     = sel_scr_q ? scr_rdata : rdata_q;
  assign debug_mode_o   = dmode;
  assign brk_req_o      = breq;
  assign brk_thread_o   = bthr;
  assign brk_index_o    = bidx;
  assign thread_hold_o  = hold;
  assign fetch_thread_o = fthr[7:0];
  assign fetch_reg_o    = freg[4:0];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  chk_pc_capture: assert property (
    debug_enter_i && !dmode |=> saved_program_counter == $past(saved_program_counter_i))
    else $error("saved pc not captured");
  chk_sp_capture: assert property (
    debug_enter_i && !dmode |=> saved_stack_pointer == $past(saved_stack_pointer_i))
    else $error("saved sp not captured");
  chk_status_capture: assert property (
    debug_enter_i && !dmode |=> status == ($past(saved_status_word_i) & DSCR_STATUS_WMASK))
    else $error("status not captured");
  chk_host_thread: assert property (
    debug_enter_i && !dmode && entry_cause_i == DSCR_CAUSE_HOST |=> cause[15:8] == 8'h00)
    else $error("host cause has thread");
  chk_call_index: assert property (
    debug_enter_i && !dmode && entry_cause_i <= DSCR_CAUSE_DEBUG_CALL_INSTRUCTION |=> cause[17:16] == 2'h0)
    else $error("index nonzero for host or call");
  chk_write_gate: assert property (
    !dmode && !debug_enter_i |=> $stable(stopm) && $stable(fthr))
    else $error("write taken outside debug");
  chk_reserved_zero: assert property (
    fthr[31:8] == 24'h00_0000 && freg[31:5] == 27'h000_0000 && cause[31:18] == 14'h0000)
    else $error("reserved bits set");
  chk_hold_exit: assert property (
    debug_exit_i && dmode |=> thread_hold_o == $past(stopm[7:0]) && !debug_mode_o)
    else $error("hold mask wrong after exit");
  chk_low_index: assert property (
    bif.hit[0] |=> brk_req_o && brk_index_o == 2'h0)
    else $error("lowest breakpoint not chosen");
  chk_issue_ro: assert property (
    ##1 ps_rd_i && ps_addr_i == DSCR_SAVED_STATUS |=>
      ps_rdata_o[DSCR_STATUS_ISSUE] == $past(issue_q))
    else $error("issue bit not live");

  cov_entry: cover property (debug_enter_i && !dmode ##1 dmode);
  cov_exit_hold: cover property (debug_exit_i && dmode && stopm[7:0] != 8'h00);
  cov_multi_hit: cover property (bif.hit[1] && bif.hit[2]);
  cov_scratch_rd: cover property (ps_rd_i && scr_hit);
endmodule
`default_nettype wire

// File: include/dscr_brk_if.sv
/*
  Carrier between the top and the breakpoint comparator bank.
  Assumes one clock domain; all signals are same-cycle combinational.
*/
`timescale 1ns/1ns
`default_nettype none
interface dscr_brk_if;
  logic [31:0] pc;
  logic [7:0]  thread;
  logic        valid;
  logic [31:0] addr  [4];
  logic [31:0] ctrl  [4];
  logic [3:0]  hit;

  modport top (output pc, output thread, output valid, output addr, output ctrl,
               input hit);
  modport bank (input pc, input thread, input valid, input addr, input ctrl,
                output hit);
endinterface
`default_nettype wire

// File: include/dscr_pkg.sv
/*
  Constants for the debug state capture block: register indices, field
  positions, reset values and cause codes.
  Assumes a 32-bit processor-status register space addressed by index.
*/
package dscr_pkg;

  // ---------------------------------------------------------------
  // Register indices
  // ---------------------------------------------------------------
  localparam logic [7:0] DSCR_SAVED_STATUS   = 8'h10;
  localparam logic [7:0] DSCR_SAVED_PC       = 8'h11;
  localparam logic [7:0] DSCR_SAVED_SP       = 8'h12;
  localparam logic [7:0] DSCR_FETCH_THREAD   = 8'h13;
  localparam logic [7:0] DSCR_FETCH_REG      = 8'h14;
  localparam logic [7:0] DSCR_CAUSE          = 8'h15;
  localparam logic [7:0] DSCR_EVENT_DATA     = 8'h16;
  localparam logic [7:0] DSCR_STOP_MASK      = 8'h18;
  localparam logic [7:0] DSCR_SCRATCH_BASE   = 8'h20;
  localparam logic [7:0] DSCR_SCRATCH_LAST   = 8'h27;
  localparam logic [7:0] DSCR_BRK_ADDR_BASE  = 8'h30;
  localparam logic [7:0] DSCR_BRK_ADDR_LAST  = 8'h33;
  localparam logic [7:0] DSCR_BRK_CTRL_BASE  = 8'h40;
  localparam logic [7:0] DSCR_BRK_CTRL_LAST  = 8'h43;

  // ---------------------------------------------------------------
  // Field layouts
  // ---------------------------------------------------------------
  localparam logic [31:0] DSCR_STATUS_WMASK  = 32'h0000_06DF;
  localparam int          DSCR_STATUS_ISSUE  = 8;
  localparam logic [31:0] DSCR_THREAD_MASK   = 32'h0000_00FF;
  localparam logic [31:0] DSCR_REGIDX_MASK   = 32'h0000_001F;
  localparam logic [31:0] DSCR_CAUSE_MASK    = 32'h0003_FF07;
  localparam logic [31:0] DSCR_BCTRL_MASK    = 32'h00FF_0003;
  localparam int          DSCR_BCTRL_EN      = 0;
  localparam int          DSCR_BCTRL_NE      = 1;
  localparam int          DSCR_BCTRL_THR_LO  = 16;
  localparam int          DSCR_NUM_BRK       = 4;
  localparam int          DSCR_NUM_SCRATCH   = 8;
  localparam logic [31:0] DSCR_RESET_WORD    = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Cause codes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    DSCR_CAUSE_NONE  = 3'h0,
    DSCR_CAUSE_HOST  = 3'h1,
    DSCR_CAUSE_DEBUG_CALL_INSTRUCTION = 3'h2,
    DSCR_CAUSE_IBRK  = 3'h3,
    DSCR_CAUSE_DWAT  = 3'h4,
    DSCR_CAUSE_RWAT  = 3'h5
  } dscr_cause_t;

endpackage

// File: tb/dscr_host_model.sv
/*
  External debugger model on the tile configuration view of scratch.
  Assumes the bench calls put and get from one process only.
*/
`timescale 1ns/1ns
`default_nettype none
module dscr_host_model (
  input  wire logic        clk_i,
  input  wire logic [31:0] rdata_i,
  output logic             wr_o,
  output logic      [2:0]  addr_o,
  output logic      [31:0] wdata_o
);
  initial begin
    wr_o    = 1'b0;
    addr_o  = 3'h0;
    wdata_o = 32'h0000_0000;
  end
  task automatic put(input logic [2:0] a, input logic [31:0] d);
    @(negedge clk_i);
    wr_o    = 1'b1;
    addr_o  = a;
    wdata_o = d;
    @(negedge clk_i);
    wr_o    = 1'b0;
    // Stale data inverted so a late capture cannot pass
    wdata_o = ~d;
  endtask
  task automatic get(input logic [2:0] a, output logic [31:0] d);
    @(negedge clk_i);
    addr_o = a;
    @(negedge clk_i);
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

// File: tb/dscr_top_test.sv
/*
  Self-checking bench for the debug state capture registers.
  Assumes the host model drives the configuration scratch port.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module dscr_top_test;
  import dscr_pkg::*;
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        ps_wr_i, ps_rd_i, cfg_wr_i, debug_enter_i, debug_exit_i;
  logic        issue_mode_i, issue_valid_i, debug_mode_o, brk_req_o;
  logic [7:0]  ps_addr_i, entry_thread_i, issue_thread_i, brk_thread_o;
  logic [7:0]  thread_hold_o, fetch_thread_o;
  logic [31:0] ps_wdata_i, ps_rdata_o, cfg_wdata_i, cfg_rdata_o, watch_data_i;
  logic [31:0] saved_status_word_i, saved_program_counter_i, saved_stack_pointer_i;
  logic [31:0] issue_pc_i, sw, pc, sp, wd, ev, d, p;
  logic [2:0]  cfg_addr_i, entry_cause_i;
  logic [1:0]  watch_index_i, brk_index_o, wi;
  logic [4:0]  fetch_reg_o;
  logic [7:0]  t, m;
  integer      seed = 32'h248f_4fdc;
  int          num_errors = 0, num_checks = 0, cycles = 0, c, i;

  dscr_top u_dut (.clk_i, .resetn_i, .ps_wr_i, .ps_rd_i, .ps_addr_i, .ps_wdata_i,
    .ps_rdata_o, .cfg_wr_i, .cfg_addr_i, .cfg_wdata_i, .cfg_rdata_o, .debug_enter_i,
    .debug_exit_i, .entry_cause_i, .entry_thread_i, .watch_index_i, .watch_data_i,
    .saved_status_word_i, .issue_mode_i, .saved_program_counter_i,
    .saved_stack_pointer_i, .issue_valid_i, .issue_pc_i, .issue_thread_i,
    .debug_mode_o, .brk_req_o, .brk_thread_o, .brk_index_o, .thread_hold_o,
    .fetch_thread_o, .fetch_reg_o);
  dscr_host_model u_host (.clk_i, .rdata_i(cfg_rdata_o), .wr_o(cfg_wr_i),
    .addr_o(cfg_addr_i), .wdata_o(cfg_wdata_i));

  always #5 clk_i = ~clk_i;
  // Run takes well under a thousand cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      conclude();
    end
  end

  // ---------------------------------------------------------------
  // Bus tasks and expectations
  // ---------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dv);
    @(negedge clk_i);
    ps_wr_i    = 1'b1;
    ps_addr_i  = a;
    ps_wdata_i = dv;
    @(negedge clk_i);
    ps_wr_i    = 1'b0;
    ps_wdata_i = ~dv;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(negedge clk_i);
    ps_rd_i   = 1'b1;
    ps_addr_i = a;
    @(negedge clk_i);
    ps_rd_i   = 1'b0;
    `CHK(nm, e, ps_rdata_o)
  endtask
  task automatic enter(input logic [2:0] cv);
    @(negedge clk_i);
    entry_cause_i = cv;
    debug_enter_i = 1'b1;
    @(negedge clk_i);
    debug_enter_i = 1'b0;
  endtask
  task automatic leave();
    @(negedge clk_i);
    debug_exit_i = 1'b1;
    @(negedge clk_i);
    debug_exit_i = 1'b0;
  endtask
  task automatic brk(input logic [31:0] a, input logic [7:0] th, input logic req,
                     input logic [1:0] ix);
    @(negedge clk_i);
    issue_valid_i  = 1'b1;
    issue_pc_i     = a;
    issue_thread_i = th;
    @(negedge clk_i);
    issue_valid_i  = 1'b0;
    `CHK("brk_req", req, brk_req_o)
    if (req) begin
      `CHK("brk_index", ix, brk_index_o)
      `CHK("brk_thread", th, brk_thread_o)
    end
  endtask
  function automatic logic [31:0] exp_cause(input logic [2:0] cv, input logic [7:0] th,
                                            input logic [1:0] ix);
    exp_cause = {14'h0000, (cv >= 3'h3) ? ix : 2'b00, (cv == 3'h1) ? 8'h00 : th, 5'h00, cv};
  endfunction
  function automatic logic [31:0] exp_stat(input logic [31:0] w);
    exp_stat = (w & DSCR_STATUS_WMASK) | (32'(issue_mode_i) << DSCR_STATUS_ISSUE);
  endfunction

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    {ps_wr_i, ps_rd_i, debug_enter_i, debug_exit_i, issue_valid_i, issue_mode_i} = '0;
    {ps_addr_i, ps_wdata_i, entry_cause_i, entry_thread_i, watch_index_i} = '0;
    {watch_data_i, saved_status_word_i, saved_program_counter_i} = '0;
    {saved_stack_pointer_i, issue_pc_i, issue_thread_i} = '0;
    ev = 32'h0000_0000;
    repeat (8) @(negedge clk_i);
    resetn_i = 1'b1;
    rd(DSCR_CAUSE, 32'h0000_0000, "cause_rst");
    wr(DSCR_STOP_MASK, 32'h0000_00FF);
    rd(DSCR_STOP_MASK, 32'h0000_0000, "mask_locked");
    for (c = 1; c <= 5; c++) begin
      sw = $random(seed);
      pc = $random(seed);
      sp = $random(seed);
      wd = $random(seed);
      t  = 8'($random(seed));
      wi = 2'($random(seed));
      {saved_status_word_i, saved_program_counter_i, saved_stack_pointer_i} = {sw, pc, sp};
      {watch_data_i, entry_thread_i, watch_index_i} = {wd, t, wi};
      issue_mode_i = sw[31];
      enter(3'(c));
      `CHK("debug_mode", 1'b1, debug_mode_o)
      `CHK("hold_all", 8'hFF, thread_hold_o)
      if (c >= 4) ev = wd;
      rd(DSCR_SAVED_STATUS, exp_stat(sw), "status");
      rd(DSCR_SAVED_PC, pc, "pc");
      rd(DSCR_SAVED_SP, sp, "sp");
      rd(DSCR_CAUSE, exp_cause(3'(c), t, wi), "cause");
      rd(DSCR_EVENT_DATA, ev, "event_data");
      rd(8'h17, 32'h0000_0000, "unmapped");
      d = ~sw;
      wr(DSCR_SAVED_STATUS, d);
      rd(DSCR_SAVED_STATUS, exp_stat(d), "status_wb");
      d = $random(seed);
      wr(DSCR_FETCH_THREAD, d);
      rd(DSCR_FETCH_THREAD, d & DSCR_THREAD_MASK, "fetch_thr");
      `CHK("fetch_thread_o", d[7:0], fetch_thread_o)
      wr(DSCR_FETCH_REG, d);
      rd(DSCR_FETCH_REG, d & DSCR_REGIDX_MASK, "fetch_reg");
      `CHK("fetch_reg_o", d[4:0], fetch_reg_o)
      m = 8'($random(seed));
      wr(DSCR_STOP_MASK, {24'hFFFF_FF, m});
      leave();
      `CHK("hold_mask", m, thread_hold_o)
    end
    enter(DSCR_CAUSE_HOST);
    for (i = 0; i < 8; i++) begin
      d = $random(seed);
      if (i[0]) begin
        wr(DSCR_SCRATCH_BASE + 8'(i), d);
        u_host.get(3'(i), p);
        `CHK("scratch_cfg", d, p)
      end else begin
        u_host.put(3'(i), d);
        rd(DSCR_SCRATCH_BASE + 8'(i), d, "scratch_ps");
      end
    end
    p = $random(seed) & 32'hFFFF_FFFC;
    for (i = 0; i < 4; i++) wr(DSCR_BRK_ADDR_BASE + 8'(i), p);
    rd(DSCR_BRK_ADDR_LAST, p, "brk_addr");
    // Slot 0 armed for thread 5 only, so the lowest slot can win a tie
    wr(DSCR_BRK_CTRL_BASE, 32'h0020_0001);
    wr(DSCR_BRK_CTRL_BASE + 8'h01, 32'h00FF_0001);
    wr(DSCR_BRK_CTRL_BASE + 8'h02, 32'h00FF_0001);
    wr(DSCR_BRK_CTRL_LAST, 32'hFF40_FFFF);
    rd(DSCR_BRK_CTRL_LAST, 32'h0040_0003, "brk_ctrl");
    brk(p, 8'h03, 1'b0, 2'b00);
    leave();
    brk(p, 8'h03, 1'b1, 2'b01);
    brk(p + 32'h0000_0004, 8'h03, 1'b0, 2'b00);
    brk(p + 32'h0000_0004, 8'h06, 1'b1, 2'b11);
    brk(p, 8'h06, 1'b1, 2'b01);
    brk(p, 8'h05, 1'b1, 2'b00);
    conclude();
  end
endmodule
`default_nettype wire
